/* rtl/psb_pkg.sv */
// constants for the paged sram and special register bank
// assumes a 4-bit core addressing a 6-bit direct data space
package psb_pkg;
   // ---------------------------------------------------------
   // address map
   // ---------------------------------------------------------
   localparam logic [5:0] PSB_OFS_STATUS = 6'h00; // status flags
   localparam logic [5:0] PSB_OFS_E_DIR  = 6'h01; // port e direction
   localparam logic [5:0] PSB_OFS_A_DIR  = 6'h02; // port a direction
   localparam logic [5:0] PSB_OFS_A_DAT  = 6'h03; // port a data
   localparam logic [5:0] PSB_OFS_C_OUT  = 6'h04; // port c output
   localparam logic [5:0] PSB_OFS_B_DIR  = 6'h05; // port b direction
   localparam logic [5:0] PSB_OFS_B_DAT  = 6'h06; // port b data
   localparam logic [5:0] PSB_OFS_SCR1   = 6'h07; // scratch one
   localparam logic [5:0] PSB_OFS_AUD_LO = 6'h08; // sample lowest
   localparam logic [5:0] PSB_OFS_PWMCTL = 6'h09; // pwm and irq control
   localparam logic [5:0] PSB_OFS_AUD_MI = 6'h0a; // sample middle
   localparam logic [5:0] PSB_OFS_AUD_HI = 6'h0b; // sample high
   localparam logic [5:0] PSB_OFS_D_DIR  = 6'h0c; // port d direction
   localparam logic [5:0] PSB_OFS_D_DAT  = 6'h0d; // port d data
   localparam logic [5:0] PSB_OFS_E_DAT  = 6'h0e; // port e data
   localparam logic [5:0] PSB_OFS_SCR2   = 6'h0f; // scratch two
   localparam logic [5:0] PSB_OFS_RSV_A  = 6'h10; // reserved
   localparam logic [5:0] PSB_OFS_FMTCTL = 6'h11; // format and input control
   localparam logic [5:0] PSB_OFS_RSV_B  = 6'h12; // reserved
   localparam logic [5:0] PSB_BIT_LIMIT  = 6'h0f; // last direct bit-op address
   localparam logic [5:0] PSB_SRAM_BASE  = 6'h20; // start of paged window
   localparam int         PSB_SRAM_DEPTH = 128;   // nibbles of sram
   // ---------------------------------------------------------
   // field positions
   // ---------------------------------------------------------
   localparam int PSB_ST_ZERO  = 0; // zero flag
   localparam int PSB_ST_CARRY = 1; // carry flag
   localparam int PSB_ST_PWMFG = 2; // pwm irq flag
   localparam int PSB_PC_PWMON = 0; // pwm on
   localparam int PSB_PC_GIRQ  = 1; // global irq on
   localparam int PSB_FC_TWOS  = 1; // twos complement select
   localparam int PSB_FC_HYST  = 2; // hysteresis input on
   localparam int PSB_SIGN_BIT = 3; // sign inside high nibble
   // ---------------------------------------------------------
   // reset values
   // ---------------------------------------------------------
   localparam logic [3:0] PSB_RST_OE_N = 4'hf; // direction 0000, all inputs
   localparam logic [3:0] PSB_RST_NIB  = 4'h0; // nibble registers
   localparam logic [1:0] PSB_RST_PAGE = 2'h0; // page select
   // sample resolution
   typedef enum logic [1:0] {
      PSB_W8  = 2'b00,
      PSB_W10 = 2'b01,
      PSB_W12 = 2'b10
   } psb_width_e;
endpackage : psb_pkg

/* rtl/psb_bank.sv */
// paged sram and special register bank of the 4-bit core
// assumes the core issues one access per enabled cycle and
// performs read-modify-write as a read followed by a write
//
// Operation
// - 128 sram nibbles, four pages, 2-bit select
// - page select undefined; software loads before use (reset here loads 00)
// - 00H-1FH always reach special registers
// - 20H-3FH reach selected page; sram unreset
// - special registers serve as ordinary operands
// - direct bit ops only at 00H-0FH
// - direction registers, 1 output, reset inputs
// - data read gives pins, write sets latch
// - port c output only, resets 0000
// - two scratch registers at 07H, 0FH
// - status holds pwm, carry, zero flags
// - pwm enable bit0, global irq bit1
// - 8-bit sample from 0AH and 0BH
// - 10-bit sample adds 08H bits 3:2
// - 12-bit sample adds full 08H nibble
// - 11H bit1 selects twos complement format
// - 11H bit2 enables port a hysteresis
`timescale 1ns/1ps
`default_nettype none
module psb_bank
   import psb_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       clk_en,
   input  wire logic [5:0] acc_addr,
   input  wire logic       acc_rd,
   input  wire logic       acc_wr,
   input  wire logic [3:0] acc_wdata,
   input  wire logic       bit_op,
   input  wire logic       bit_indirect,
   input  wire logic [1:0] bit_pos,
   input  wire logic       bit_value,
   input  wire logic       load_page_select_instr,
   input  wire logic [1:0] page_value,
   input  wire logic       flag_wr,
   input  wire logic       carry_in,
   input  wire logic       zero_in,
   input  wire logic       pwm_irq_set,
   input  wire logic       ten_bit_option,
   input  wire logic       twelve_bit_option,
   input  wire logic [3:0] pa_in,
   input  wire logic [3:0] pb_in,
   input  wire logic [3:0] pd_in,
   input  wire logic [3:0] pe_in,
   output logic      [3:0] acc_rdata,
   output logic            acc_rvalid,
   output logic      [3:0] pa_out,
   output logic      [3:0] pa_oe_n,
   output logic      [3:0] pb_out,
   output logic      [3:0] pb_oe_n,
   output logic      [3:0] pd_out,
   output logic      [3:0] pd_oe_n,
   output logic      [3:0] pe_out,
   output logic      [3:0] pe_oe_n,
   output logic      [3:0] pc_out,
   output logic      [1:0] sram_page_select,
   output logic            pwm_irq_flag,
   output logic            carry_flag,
   output logic            zero_flag,
   output logic            pwm_on,
   output logic            global_irq_on,
   output logic            twos_complement_select,
   output logic            hysteresis_input_on,
   output logic     [11:0] audio_sample,
   output logic      [1:0] sample_width,
   output logic            sample_sign_bit
);
   // ---------------------------------------------------------
   // helpers
   // ---------------------------------------------------------
   // true for the paged sram window
   function automatic logic is_sram(input logic [5:0] a);
      is_sram = (a >= PSB_SRAM_BASE);
   endfunction : is_sram

   // nibble with one bit forced
   function automatic logic [3:0] put_bit(input logic [3:0] v,
                                          input logic [1:0] p,
                                          input logic       b);
      logic [3:0] r;
      r    = v;
      r[p] = b;
      put_bit = r;
   endfunction : put_bit

   // ---------------------------------------------------------
   // reset release
   // ---------------------------------------------------------
   logic [1:0] rsync_q;   // release shifter
   logic       rst_i_n;   // synchronised reset

   // assert at once, release after two edges
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rsync_q <= 2'b00;
      end else begin
         rsync_q <= {rsync_q[0], 1'b1};
      end
   end
   assign rst_i_n = rsync_q[1];

   // ---------------------------------------------------------
   // pin input conditioning
   // ---------------------------------------------------------
   logic [15:0] pin_s1_q; // first stage, read only by second
   logic [15:0] pin_s2_q; // second stage
   logic [15:0] pin_s3_q; // third stage
   logic [15:0] pin_q;    // accepted level

   // three stages; a bit moves once stages two and three agree
   always_ff @(posedge clock or negedge rst_i_n) begin
      if (!rst_i_n) begin
         pin_s1_q <= 16'h0000;
         pin_s2_q <= 16'h0000;
         pin_s3_q <= 16'h0000;
         pin_q    <= 16'h0000;
      end else if (clk_en) begin
         pin_s1_q <= {pe_in, pd_in, pb_in, pa_in};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         pin_q    <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q | pin_s3_q));
      end
   end

   // ---------------------------------------------------------
   // storage
   // ---------------------------------------------------------
   logic [3:0] sram_q [0:PSB_SRAM_DEPTH-1]; // paged nibbles
   logic [3:0] scr1_q;      // scratch one
   logic [3:0] scr2_q;      // scratch two
   logic [3:0] aud_lo_q;    // sample lowest
   logic [3:0] aud_mi_q;    // sample middle
   logic [3:0] aud_hi_q;    // sample high
   logic [3:0] cur;         // stored value at address
   logic [3:0] rd_mux;      // value a read returns
   logic       bit_ok;      // bit op honoured
   logic       wr_en;       // effective write
   logic [3:0] wr_data;     // effective write data
   logic [6:0] sram_idx;    // page plus offset

   assign sram_idx = {sram_page_select, acc_addr[4:0]};

   // ---------------------------------------------------------
   // access decode
   // ---------------------------------------------------------
   // direct bit ops above the limit are dropped silently
   assign bit_ok  = bit_op & (bit_indirect | (acc_addr <= PSB_BIT_LIMIT));
   assign wr_en   = acc_wr | bit_ok;
   // bit ops modify the latch, never the pin level
   assign wr_data = bit_ok ? put_bit(cur, bit_pos, bit_value) : acc_wdata;

   // stored value and read value per address
   always_comb begin
      cur    = 4'h0;
      rd_mux = 4'h0;
      if (is_sram(acc_addr)) begin
         cur = sram_q[sram_idx];
      end else begin
         case (acc_addr)
            PSB_OFS_STATUS: cur = {1'b0, pwm_irq_flag, carry_flag, zero_flag};
            PSB_OFS_E_DIR:  cur = ~pe_oe_n;
            PSB_OFS_A_DIR:  cur = ~pa_oe_n;
            PSB_OFS_A_DAT:  cur = pa_out;
            PSB_OFS_C_OUT:  cur = pc_out;
            PSB_OFS_B_DIR:  cur = ~pb_oe_n;
            PSB_OFS_B_DAT:  cur = pb_out;
            PSB_OFS_SCR1:   cur = scr1_q;
            PSB_OFS_PWMCTL: cur = {2'b00, global_irq_on, pwm_on};
            PSB_OFS_D_DIR:  cur = ~pd_oe_n;
            PSB_OFS_D_DAT:  cur = pd_out;
            PSB_OFS_E_DAT:  cur = pe_out;
            PSB_OFS_SCR2:   cur = scr2_q;
            PSB_OFS_FMTCTL: cur = {1'b0, hysteresis_input_on, twos_complement_select, 1'b0};
            default:        cur = 4'h0; // write-only, reserved, outside block
         endcase
      end
      // data registers read the pins
      case (acc_addr)
         PSB_OFS_A_DAT: rd_mux = pin_q[3:0];
         PSB_OFS_B_DAT: rd_mux = pin_q[7:4];
         PSB_OFS_D_DAT: rd_mux = pin_q[11:8];
         PSB_OFS_E_DAT: rd_mux = pin_q[15:12];
         default:       rd_mux = cur;
      endcase
   end

   // registered read answer, one cycle after the request
   always_ff @(posedge clock or negedge rst_i_n) begin
      if (!rst_i_n) begin
         acc_rdata  <= 4'h0;
         acc_rvalid <= 1'b0;
      end else if (clk_en) begin
         acc_rvalid <= acc_rd;
         if (acc_rd) begin
            acc_rdata <= rd_mux;
         end
      end
   end

   // ---------------------------------------------------------
   // sram and page select
   // ---------------------------------------------------------
   // no reset on the array: content is undefined at power-up
   always_ff @(posedge clock) begin
      if (clk_en && wr_en && is_sram(acc_addr)) begin
         sram_q[sram_idx] <= wr_data;
      end
   end

   // reset value is a convenience only; software must load it
   always_ff @(posedge clock or negedge rst_i_n) begin
      if (!rst_i_n) begin
         sram_page_select <= PSB_RST_PAGE;
      end else if (clk_en && load_page_select_instr) begin
         sram_page_select <= page_value;
      end
   end

   // ---------------------------------------------------------
   // status flags
   // ---------------------------------------------------------
   // core flag update beats a same-cycle write; pwm set beats clear
   always_ff @(posedge clock or negedge rst_i_n) begin
      if (!rst_i_n) begin
         pwm_irq_flag <= 1'b0;
         carry_flag   <= 1'b0;
         zero_flag    <= 1'b0;
      end else if (clk_en) begin
         if (pwm_irq_set) begin
            pwm_irq_flag <= 1'b1;
         end else if (wr_en && acc_addr == PSB_OFS_STATUS) begin
            pwm_irq_flag <= wr_data[PSB_ST_PWMFG];
         end
         if (flag_wr) begin
            carry_flag <= carry_in;
            zero_flag  <= zero_in;
         end else if (wr_en && acc_addr == PSB_OFS_STATUS) begin
            carry_flag <= wr_data[PSB_ST_CARRY];
            zero_flag  <= wr_data[PSB_ST_ZERO];
         end
      end
   end

   // ---------------------------------------------------------
   // ports
   // ---------------------------------------------------------
   // direction kept inverted so enables leave straight from flops
   always_ff @(posedge clock or negedge rst_i_n) begin
      if (!rst_i_n) begin
         pa_oe_n <= PSB_RST_OE_N;
         pb_oe_n <= PSB_RST_OE_N;
         pd_oe_n <= PSB_RST_OE_N;
         pe_oe_n <= PSB_RST_OE_N;
      end else if (clk_en && wr_en) begin
         case (acc_addr)
            PSB_OFS_A_DIR: pa_oe_n <= ~wr_data;
            PSB_OFS_B_DIR: pb_oe_n <= ~wr_data;
            PSB_OFS_D_DIR: pd_oe_n <= ~wr_data;
            PSB_OFS_E_DIR: pe_oe_n <= ~wr_data;
            default: ;
         endcase
      end
   end

   // output latches and port c
   always_ff @(posedge clock or negedge rst_i_n) begin
      if (!rst_i_n) begin
         pa_out <= PSB_RST_NIB;
         pb_out <= PSB_RST_NIB;
         pd_out <= PSB_RST_NIB;
         pe_out <= PSB_RST_NIB;
         pc_out <= PSB_RST_NIB;
      end else if (clk_en && wr_en) begin
         case (acc_addr)
            PSB_OFS_A_DAT: pa_out <= wr_data;
            PSB_OFS_B_DAT: pb_out <= wr_data;
            PSB_OFS_D_DAT: pd_out <= wr_data;
            PSB_OFS_E_DAT: pe_out <= wr_data;
            PSB_OFS_C_OUT: pc_out <= wr_data;
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------
   // scratch, control and sample nibbles
   // ---------------------------------------------------------
   // reserved slots have no case item, so their writes vanish
   always_ff @(posedge clock or negedge rst_i_n) begin
      if (!rst_i_n) begin
         scr1_q                 <= PSB_RST_NIB;
         scr2_q                 <= PSB_RST_NIB;
         aud_lo_q               <= PSB_RST_NIB;
         aud_mi_q               <= PSB_RST_NIB;
         aud_hi_q               <= PSB_RST_NIB;
         pwm_on                 <= 1'b0;
         global_irq_on          <= 1'b0;
         twos_complement_select <= 1'b0;
         hysteresis_input_on    <= 1'b0;
      end else if (clk_en && wr_en) begin
         case (acc_addr)
            PSB_OFS_SCR1:   scr1_q   <= wr_data;
            PSB_OFS_SCR2:   scr2_q   <= wr_data;
            PSB_OFS_AUD_LO: aud_lo_q <= wr_data;
            PSB_OFS_AUD_MI: aud_mi_q <= wr_data;
            PSB_OFS_AUD_HI: aud_hi_q <= wr_data;
            PSB_OFS_PWMCTL: begin
               pwm_on        <= wr_data[PSB_PC_PWMON];
               global_irq_on <= wr_data[PSB_PC_GIRQ];
            end
            PSB_OFS_FMTCTL: begin
               twos_complement_select <= wr_data[PSB_FC_TWOS];
               hysteresis_input_on    <= wr_data[PSB_FC_HYST];
            end
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------
   // sample assembly
   // ---------------------------------------------------------
   psb_width_e width_d; // resolution from the options

   // twelve-bit option outranks ten-bit
   always_comb begin
      if (twelve_bit_option) begin
         width_d = PSB_W12;
      end else if (ten_bit_option) begin
         width_d = PSB_W10;
      end else begin
         width_d = PSB_W8;
      end
   end

   // one cycle behind the nibbles; the engine samples at its own pace
   always_ff @(posedge clock or negedge rst_i_n) begin
      if (!rst_i_n) begin
         audio_sample    <= 12'h000;
         sample_width    <= PSB_W8;
         sample_sign_bit <= 1'b0;
      end else if (clk_en) begin
         sample_width    <= width_d;
         sample_sign_bit <= aud_hi_q[PSB_SIGN_BIT];
         case (width_d)
            PSB_W12: audio_sample <= {aud_hi_q, aud_mi_q, aud_lo_q};
            PSB_W10: audio_sample <= {2'b00, aud_hi_q, aud_mi_q, aud_lo_q[3:2]};
            PSB_W8:  audio_sample <= {4'h0, aud_hi_q, aud_mi_q};
            default: audio_sample <= {4'h0, aud_hi_q, aud_mi_q};
         endcase
      end
   end

   // ---------------------------------------------------------
   // assertions
   // ---------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_i_n);

   a_page_load: assert property (clk_en && load_page_select_instr |=>
      sram_page_select == $past(page_value)) else $error("page select not loaded");
   a_sram_back: assert property (clk_en && wr_en && is_sram(acc_addr) ##1
      clk_en && acc_rd && !wr_en && acc_addr == $past(acc_addr) &&
      !$past(load_page_select_instr) |=> acc_rdata == $past(wr_data, 2))
      else $error("sram readback wrong");
   a_scr_back: assert property (clk_en && wr_en && acc_addr == PSB_OFS_SCR1 ##1
      clk_en && acc_rd && !wr_en && acc_addr == PSB_OFS_SCR1 |=>
      acc_rdata == $past(wr_data, 2)) else $error("scratch readback wrong");
   a_dir_write: assert property (clk_en && wr_en && acc_addr == PSB_OFS_A_DIR |=>
      pa_oe_n == ~$past(wr_data)) else $error("direction not stored");
   a_pin_read: assert property (clk_en && acc_rd && acc_addr == PSB_OFS_B_DAT |=>
      acc_rdata == $past(pin_q[7:4])) else $error("port read not from pins");
   a_portc_out: assert property (clk_en && wr_en && acc_addr == PSB_OFS_C_OUT |=>
      pc_out == $past(wr_data)) else $error("port c not driven");
   a_bit_block: assert property (bit_op && !bit_indirect && !acc_wr &&
      acc_addr > PSB_BIT_LIMIT |=> $stable(twos_complement_select) &&
      $stable(hysteresis_input_on)) else $error("direct bit op above limit");
   a_pwm_flag: assert property (clk_en && pwm_irq_set |=> pwm_irq_flag)
      else $error("pwm flag not set");
   a_pwm_ctl: assert property (clk_en && wr_en && acc_addr == PSB_OFS_PWMCTL |=>
      pwm_on == $past(wr_data[0]) && global_irq_on == $past(wr_data[1]))
      else $error("pwm control not stored");
   a_sample_w8: assert property (clk_en && !twelve_bit_option && !ten_bit_option |=>
      audio_sample == {4'h0, $past(aud_hi_q), $past(aud_mi_q)}) else $error("8-bit sample");
   a_sample_w10: assert property (clk_en && !twelve_bit_option && ten_bit_option |=>
      audio_sample[1:0] == $past(aud_lo_q[3:2]) && audio_sample[9:6] == $past(aud_hi_q))
      else $error("10-bit sample");
   a_sample_w12: assert property (clk_en && twelve_bit_option |=>
      audio_sample == {$past(aud_hi_q), $past(aud_mi_q), $past(aud_lo_q)})
      else $error("12-bit sample");
   a_sign_path: assert property (clk_en && wr_en && acc_addr == PSB_OFS_AUD_HI
      ##1 clk_en |=> sample_sign_bit == $past(wr_data[3], 2)) else $error("sign bit");
   a_fmt_ctl: assert property (clk_en && wr_en && acc_addr == PSB_OFS_FMTCTL |=>
      twos_complement_select == $past(wr_data[1]) && hysteresis_input_on ==
      $past(wr_data[2])) else $error("format control not stored");
   a_rsv_read: assert property (clk_en && acc_rd && acc_addr == PSB_OFS_RSV_B |=>
      acc_rdata == 4'h0) else $error("reserved read not zero");

   c_page_switch: cover property (load_page_select_instr ##1 wr_en && is_sram(acc_addr));
   c_bit_direct:  cover property (bit_ok && !bit_indirect);
   c_flag_race:   cover property (pwm_irq_set && wr_en && acc_addr == PSB_OFS_STATUS);
   c_w12_sample:  cover property (sample_width == PSB_W12 && audio_sample[11]);
endmodule : psb_bank
`default_nettype wire

/* bench/psb_pads.sv */
// pad ring model for the four two-way ports of the bank
// assumes active-low output enables; undriven pins follow ext
`timescale 1ns/1ps
`default_nettype none
module psb_pads (
   input  wire logic [15:0] oe_n, // low drives the pad
   input  wire logic [15:0] dout, // bank output latches
   input  wire logic [15:0] ext,  // outside drivers
   output logic      [15:0] pin   // resolved pad level
);
   // an enabled pin shows its latch, a released one the outside level
   always_comb pin = (~oe_n & dout) | (oe_n & ext);
endmodule : psb_pads
`default_nettype wire

/* bench/psb_bank_bench.sv */
// self-checking bench for the paged sram and special register bank
// assumes one clock; all inputs move on the falling edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module psb_bank_bench import psb_pkg::*; ;
   logic clock = 0, rst_n = 0, clk_en = 1, acc_rd = 0, acc_wr = 0;
   logic bit_op = 0, bit_indirect = 0, bit_value = 0, load_page_select_instr = 0;
   logic flag_wr = 0, carry_in = 0, zero_in = 0, pwm_irq_set = 0;
   logic ten_bit_option = 0, twelve_bit_option = 0;
   logic [5:0] acc_addr = 0;
   logic [3:0] acc_wdata = 0, acc_rdata, pa_out, pb_out, pd_out, pe_out, pc_out;
   logic [3:0] pa_oe_n, pb_oe_n, pd_oe_n, pe_oe_n;
   logic [1:0] bit_pos = 0, page_value = 0, sram_page_select, sample_width;
   logic acc_rvalid, pwm_irq_flag, carry_flag, zero_flag, pwm_on, global_irq_on;
   logic twos_complement_select, hysteresis_input_on, sample_sign_bit;
   logic [11:0] audio_sample;
   logic [15:0] ext = 0, pin, oe_all, out_all;
   int failures = 0, num_checks = 0;
   assign oe_all = {pe_oe_n, pd_oe_n, pb_oe_n, pa_oe_n};
   assign out_all = {pe_out, pd_out, pb_out, pa_out};
   psb_bank psb_bank_inst (.clock, .rst_n, .clk_en, .acc_addr, .acc_rd, .acc_wr,
      .acc_wdata, .bit_op, .bit_indirect, .bit_pos, .bit_value, .load_page_select_instr,
      .page_value, .flag_wr, .carry_in, .zero_in, .pwm_irq_set, .ten_bit_option,
      .twelve_bit_option, .pa_in(pin[3:0]), .pb_in(pin[7:4]), .pd_in(pin[11:8]),
      .pe_in(pin[15:12]), .acc_rdata, .acc_rvalid, .pa_out, .pa_oe_n, .pb_out, .pb_oe_n,
      .pd_out, .pd_oe_n, .pe_out, .pe_oe_n, .pc_out, .sram_page_select, .pwm_irq_flag,
      .carry_flag, .zero_flag, .pwm_on, .global_irq_on, .twos_complement_select,
      .hysteresis_input_on, .audio_sample, .sample_width, .sample_sign_bit);
   psb_pads psb_pads_inst (.oe_n(oe_all), .dout(out_all), .ext(ext), .pin(pin));
   // 200 MHz clock
   initial forever #2.5 clock = ~clock;
   // ---------------------------------------------------------
   // core-side access tasks, one request per enabled cycle
   // ---------------------------------------------------------
   task automatic wr(input logic [5:0] a, input logic [3:0] d);
      @(negedge clock);
      acc_addr = a;
      acc_wdata = d;
      acc_wr = 1;
      @(negedge clock);
      acc_wr = 0;
   endtask : wr
   // read and compare valid plus data in the answer cycle
   task automatic chk_rd(input logic [5:0] a, input logic [3:0] e);
      @(negedge clock);
      acc_addr = a;
      acc_rd = 1;
      @(negedge clock);
      acc_rd = 0;
      `CHK({acc_rvalid, acc_rdata}, {1'b1, e})
   endtask : chk_rd
   // write, then read the same address on the very next edge
   task automatic wr_rd(input logic [5:0] a, input logic [3:0] d);
      @(negedge clock);
      acc_addr = a;
      acc_wdata = d;
      acc_wr = 1;
      @(negedge clock);
      acc_wr = 0;
      acc_rd = 1;
      @(negedge clock);
      acc_rd = 0;
      `CHK({acc_rvalid, acc_rdata}, {1'b1, d})
   endtask : wr_rd
   task automatic bop(input logic [5:0] a, input logic ind, input logic [1:0] p);
      @(negedge clock);
      acc_addr = a;
      bit_indirect = ind;
      bit_pos = p;
      bit_value = 1;
      bit_op = 1;
      @(negedge clock);
      bit_op = 0;
   endtask : bop
   task automatic pg(input logic [1:0] p);
      @(negedge clock);
      page_value = p;
      load_page_select_instr = 1;
      @(negedge clock);
      load_page_select_instr = 0;
      `CHK(sram_page_select, p)
   endtask : pg
   // expected sample for a resolution; the twelve-bit option wins
   function automatic logic [11:0] smp(input logic t, w, input logic [3:0] l, m, h);
      return w ? {h, m, l} : t ? {2'b0, h, m, l[3:2]} : {4'b0, h, m};
   endfunction : smp
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #100000;
      failures++;
      tally_and_finish();
   end
   initial begin
      logic [3:0] mem [4][4];
      logic [3:0] v, d, l, m, h;
      logic [5:0] da [4];
      logic [5:0] pa [4];
      da = '{PSB_OFS_A_DIR, PSB_OFS_B_DIR, PSB_OFS_D_DIR, PSB_OFS_E_DIR};
      pa = '{PSB_OFS_A_DAT, PSB_OFS_B_DAT, PSB_OFS_D_DAT, PSB_OFS_E_DAT};
      void'($urandom(32'h94f7));
      repeat (16) @(negedge clock);
      rst_n = 1;
      repeat (3) @(negedge clock);
      `CHK({oe_all, pc_out, pwm_on}, 21'h1fffe0)
      chk_rd(PSB_OFS_FMTCTL, 4'h0);
      $display("test reset done");
      // random data in every page, incl. both window ends
      for (int p = 0; p < 4; p++) begin
         pg(p[1:0]);
         for (int k = 0; k < 4; k++) begin
            mem[p][k] = 4'($urandom);
            wr(6'h20 + 6'(k * 10 + k / 3), mem[p][k]);
         end
      end
      v = 4'($urandom);
      wr(PSB_OFS_SCR1, v);
      for (int p = 3; p >= 0; p--) begin
         pg(p[1:0]);
         for (int k = 0; k < 4; k++) chk_rd(6'h20 + 6'(k * 10 + k / 3), mem[p][k]);
         chk_rd(PSB_OFS_SCR1, v);
      end
      // read straight after write, page 0 still selected
      wr_rd(6'h3f, ~v);
      wr_rd(PSB_OFS_SCR1, ~v);
      $display("test pages done");
      for (int i = 0; i < 4; i++) begin
         d = 4'($urandom);
         v = 4'($urandom);
         wr(da[i], d);
         wr(pa[i], v);
         `CHK({oe_all[4*i+:4], out_all[4*i+:4]}, {~d, v})
         ext[4*i+:4] = 4'($urandom);
         repeat (6) @(negedge clock);
         chk_rd(pa[i], (d & v) | (~d & ext[4*i+:4]));
      end
      v = 4'($urandom);
      wr(PSB_OFS_C_OUT, v);
      `CHK(pc_out, v)
      $display("test ports done");
      wr(PSB_OFS_SCR2, 4'h0);
      bop(PSB_OFS_SCR2, 0, 2'd2);
      chk_rd(PSB_OFS_SCR2, 4'h4);
      bop(PSB_OFS_FMTCTL, 0, 2'd1);
      chk_rd(PSB_OFS_FMTCTL, 4'h0);
      bop(PSB_OFS_FMTCTL, 1, 2'd1);
      chk_rd(PSB_OFS_FMTCTL, 4'h2);
      wr(PSB_OFS_FMTCTL, 4'h4);
      `CHK({hysteresis_input_on, twos_complement_select}, 2'b10)
      $display("test bits done");
      wr(PSB_OFS_STATUS, 4'h0);
      // core flags and pwm event race a status write in one cycle
      @(negedge clock);
      {acc_addr, acc_wdata, acc_wr} = {PSB_OFS_STATUS, 4'h1, 1'b1};
      {flag_wr, carry_in, zero_in, pwm_irq_set} = 4'b1101;
      @(negedge clock);
      {acc_wr, flag_wr, pwm_irq_set} = 3'b000;
      chk_rd(PSB_OFS_STATUS, 4'h6);
      wr(PSB_OFS_STATUS, 4'h9);
      `CHK({pwm_irq_flag, carry_flag, zero_flag}, 3'b001)
      chk_rd(PSB_OFS_STATUS, 4'h1);
      wr(PSB_OFS_PWMCTL, 4'h3);
      `CHK({global_irq_on, pwm_on}, 2'b11)
      wr(PSB_OFS_PWMCTL, 4'h2);
      `CHK({global_irq_on, pwm_on}, 2'b10)
      $display("test flags done");
      for (int w = 0; w < 4; w++) begin
         {twelve_bit_option, ten_bit_option} = w[1:0];
         l = 4'($urandom);
         m = 4'($urandom);
         h = 4'($urandom) | {w[0], 3'b0};
         wr(PSB_OFS_AUD_LO, l);
         wr(PSB_OFS_AUD_MI, m);
         wr(PSB_OFS_AUD_HI, h);
         repeat (2) @(negedge clock);
         `CHK(audio_sample, smp(w[0], w[1], l, m, h))
         `CHK({sample_sign_bit, sample_width}, {h[3], w[1], w == 1})
      end
      chk_rd(PSB_OFS_AUD_MI, 4'h0);
      $display("test samples done");
      v = 4'($urandom);
      wr(PSB_OFS_SCR1, v);
      wr(PSB_OFS_RSV_A, ~v);
      wr(PSB_OFS_RSV_B, ~v);
      chk_rd(PSB_OFS_RSV_A, 4'h0);
      chk_rd(PSB_OFS_RSV_B, 4'h0);
      chk_rd(PSB_OFS_SCR1, v);
      // a write while the enable is low must leave no trace
      clk_en = 0;
      wr(PSB_OFS_SCR1, ~v);
      clk_en = 1;
      chk_rd(PSB_OFS_SCR1, v);
      $display("test reserved done");
      tally_and_finish();
   end
endmodule : psb_bank_bench
`default_nettype wire
